// ---- rtl/cmp_ctrl_pkg.sv ----
// Constants for the window comparator control block.
// Assumes an APB slave with 32-bit data and one aligned word per register.
package cmp_ctrl_pkg;
   localparam logic [11:0] OFS_CLK_EN   = 12'h000;
   localparam logic [11:0] OFS_RST_CTL  = 12'h004;
   localparam logic [11:0] OFS_MODE     = 12'h008;
   localparam logic [11:0] OFS_IRQ_FLAG = 12'h00c;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h010;
   localparam logic [11:0] OFS_OUT_CTL  = 12'h014;

   localparam int CLK_GATE_BIT = 5;
   localparam int BLK_RST_BIT  = 5;
   localparam int C1_MON_BIT   = 7;
   localparam int C1_WIN_BIT   = 5;
   localparam int C1_ENB_BIT   = 4;
   localparam int C0_MON_BIT   = 3;
   localparam int C0_WIN_BIT   = 1;
   localparam int C0_ENB_BIT   = 0;
   localparam int FLAG0_BIT    = 4;
   localparam int FLAG1_BIT    = 5;
   localparam int OUT_INV_BIT  = 0;

   localparam logic [7:0] CLK_EN_RST  = 8'h00;
   localparam logic [7:0] RST_CTL_RST = 8'h00;
   localparam logic [7:0] MODE_RST    = 8'h00;
   localparam logic [7:0] MASK_RST    = 8'h30;
   localparam logic [7:0] OUT_CTL_RST = 8'h00;

   localparam logic [7:0] CLK_EN_WMASK  = 8'h20;
   localparam logic [7:0] RST_CTL_WMASK = 8'h20;
   localparam logic [7:0] MODE_WMASK    = 8'h33;
   localparam logic [7:0] MASK_WMASK    = 8'h30;
   localparam logic [7:0] OUT_CTL_WMASK = 8'h01;
endpackage

// ---- rtl/cmp_channel.sv ----
// One comparator channel: result register and rising-edge event.
// Assumes the comparator decisions arrive synchronous to pclk.
`timescale 1ns/1ps
module cmp_channel
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic run,
   input  wire logic blk_rst,
   input  wire logic enable,
   input  wire logic window,
   input  wire logic above_high,
   input  wire logic below_low,
   output logic      result_ff,
   output logic      rise_ff
);
   logic nxt_result;

   always_comb
   begin
      nxt_result = above_high;
      if (window)
      begin
         nxt_result = above_high | below_low;
      end
      if (!enable)
      begin
         nxt_result = 1'b0;
      end
   end

   // Clock gate off freezes the channel; block reset clears it
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         result_ff <= 1'b0;
      end
      else if (blk_rst)
      begin
         result_ff <= 1'b0;
      end
      else if (run)
      begin
         result_ff <= nxt_result;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rise_ff <= 1'b0;
      end
      else
      begin
         rise_ff <= run & !blk_rst & nxt_result & !result_ff;
      end
   end
endmodule

// ---- rtl/cmp_flags.sv ----
// Sticky request flags for both comparators and the masked interrupt.
// Assumes clear strobes come from a qualified register write.
`timescale 1ns/1ps
module cmp_flags
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [1:0] set,
   input  wire logic       clr_wr,
   input  wire logic [1:0] wdata,
   input  wire logic [1:0] mask,
   output logic      [1:0] flag_ff,
   output logic            irq
);
   genvar i;
   generate
      for (i = 0; i < 2; i++)
      begin : g_flag
         // A new event wins over a clear in the same cycle
         always_ff @(posedge pclk or negedge presetn)
         begin
            if (!presetn)
            begin
               flag_ff[i] <= 1'b0;
            end
            else if (set[i])
            begin
               flag_ff[i] <= 1'b1;
            end
            else if (clr_wr && !wdata[i])
            begin
               flag_ff[i] <= 1'b0;
            end
         end
      end
   endgenerate

   assign irq = |(flag_ff & ~mask);
endmodule

// ---- rtl/cmp_ctrl_top.sv ----
// Window comparator control: APB registers, two channels, pin and IRQ.
// Assumes comparator decisions are synchronous to pclk.
//
// Decided for this implementation: the APB interface to the registers and the address map.
`timescale 1ns/1ps
module cmp_ctrl_top
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic [11:0] paddr,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] pwdata,
   input  wire logic [3:0]  pstrb,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        c0_above_high,
   input  wire logic        c0_below_low,
   input  wire logic        c1_above_high,
   input  wire logic        c1_below_low,
   output logic             compare_result_pin,
   output logic             irq
);
   logic [7:0]  clk_en_ff;
   logic [7:0]  rst_ctl_ff;
   logic [7:0]  mode_ff;
   logic [7:0]  mask_ff;
   logic [7:0]  out_ctl_ff;
   logic [31:0] prdata_ff;
   logic        pin_ff;
   logic [7:0]  rd_val;
   logic [7:0]  mode_view;
   logic [1:0]  flag_ff;
   logic [1:0]  res;
   logic [1:0]  rise;
   logic [1:0]  en;
   logic [1:0]  win;
   logic [1:0]  above;
   logic [1:0]  below;
   logic        gate;
   logic        blk_rst;
   logic        run;
   logic        addr_ok;
   logic        wr;
   logic        rd_setup;

   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   assign gate    = clk_en_ff[cmp_ctrl_pkg::CLK_GATE_BIT];
   assign blk_rst = rst_ctl_ff[cmp_ctrl_pkg::BLK_RST_BIT];
   assign run     = gate & !blk_rst;

   assign addr_ok = (paddr == cmp_ctrl_pkg::OFS_CLK_EN)
                 || (paddr == cmp_ctrl_pkg::OFS_RST_CTL)
                 || (paddr == cmp_ctrl_pkg::OFS_MODE)
                 || (paddr == cmp_ctrl_pkg::OFS_IRQ_FLAG)
                 || (paddr == cmp_ctrl_pkg::OFS_IRQ_MASK)
                 || (paddr == cmp_ctrl_pkg::OFS_OUT_CTL);

   // Zero wait states; only the low byte lane carries data
   assign pready   = 1'b1;
   assign pslverr  = psel & penable & !addr_ok;
   assign wr       = psel & penable & pwrite & pstrb[0] & addr_ok;
   assign rd_setup = psel & !penable & !pwrite;
   assign prdata   = prdata_ff;
   assign compare_result_pin = pin_ff;

   assign en    = {mode_ff[cmp_ctrl_pkg::C1_ENB_BIT],
                   mode_ff[cmp_ctrl_pkg::C0_ENB_BIT]};
   assign win   = {mode_ff[cmp_ctrl_pkg::C1_WIN_BIT],
                   mode_ff[cmp_ctrl_pkg::C0_WIN_BIT]};
   assign above = {c1_above_high, c0_above_high};
   assign below = {c1_below_low, c0_below_low};

   genvar i;
   generate
      for (i = 0; i < 2; i++)
      begin : g_cmp
         cmp_channel u_chan
         (
            .pclk       (pclk),
            .presetn    (presetn),
            .run        (run),
            .blk_rst    (blk_rst),
            .enable     (en[i]),
            .window     (win[i]),
            .above_high (above[i]),
            .below_low  (below[i]),
            .result_ff  (res[i]),
            .rise_ff    (rise[i])
         );
      end
   endgenerate

   cmp_flags u_flags
   (
      .pclk    (pclk),
      .presetn (presetn),
      .set     (rise),
      .clr_wr  (wr && paddr == cmp_ctrl_pkg::OFS_IRQ_FLAG),
      .wdata   ({pwdata[cmp_ctrl_pkg::FLAG1_BIT],
                 pwdata[cmp_ctrl_pkg::FLAG0_BIT]}),
      .mask    ({mask_ff[cmp_ctrl_pkg::FLAG1_BIT],
                 mask_ff[cmp_ctrl_pkg::FLAG0_BIT]}),
      .flag_ff (flag_ff),
      .irq     (irq)
   );

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         clk_en_ff <= cmp_ctrl_pkg::CLK_EN_RST;
      end
      else if (wr && paddr == cmp_ctrl_pkg::OFS_CLK_EN)
      begin
         clk_en_ff <= pwdata[7:0] & cmp_ctrl_pkg::CLK_EN_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         rst_ctl_ff <= cmp_ctrl_pkg::RST_CTL_RST;
      end
      else if (wr && paddr == cmp_ctrl_pkg::OFS_RST_CTL)
      begin
         rst_ctl_ff <= pwdata[7:0] & cmp_ctrl_pkg::RST_CTL_WMASK;
      end
   end

   // Block settings need the gated clock and are cleared by block reset
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mode_ff <= cmp_ctrl_pkg::MODE_RST;
      end
      else if (blk_rst)
      begin
         mode_ff <= cmp_ctrl_pkg::MODE_RST;
      end
      else if (gate && wr && paddr == cmp_ctrl_pkg::OFS_MODE)
      begin
         mode_ff <= pwdata[7:0] & cmp_ctrl_pkg::MODE_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         out_ctl_ff <= cmp_ctrl_pkg::OUT_CTL_RST;
      end
      else if (blk_rst)
      begin
         out_ctl_ff <= cmp_ctrl_pkg::OUT_CTL_RST;
      end
      else if (gate && wr && paddr == cmp_ctrl_pkg::OFS_OUT_CTL)
      begin
         out_ctl_ff <= pwdata[7:0] & cmp_ctrl_pkg::OUT_CTL_WMASK;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mask_ff <= cmp_ctrl_pkg::MASK_RST;
      end
      else if (wr && paddr == cmp_ctrl_pkg::OFS_IRQ_MASK)
      begin
         mask_ff <= pwdata[7:0] & cmp_ctrl_pkg::MASK_WMASK;
      end
   end

   // Pin follows the second result, optionally inverted
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin_ff <= 1'b0;
      end
      else
      begin
         pin_ff <= res[1]
                   ^ out_ctl_ff[cmp_ctrl_pkg::OUT_INV_BIT];
      end
   end

   always_comb
   begin
      mode_view = mode_ff;
      mode_view[cmp_ctrl_pkg::C1_MON_BIT] = res[1];
      mode_view[cmp_ctrl_pkg::C0_MON_BIT] = res[0];
   end

   always_comb
   begin
      rd_val = 8'h00;
      unique case (paddr)
         cmp_ctrl_pkg::OFS_CLK_EN:   rd_val = clk_en_ff;
         cmp_ctrl_pkg::OFS_RST_CTL:  rd_val = rst_ctl_ff;
         cmp_ctrl_pkg::OFS_MODE:     rd_val = mode_view;
         cmp_ctrl_pkg::OFS_IRQ_FLAG:
         begin
            rd_val[cmp_ctrl_pkg::FLAG1_BIT] = flag_ff[1];
            rd_val[cmp_ctrl_pkg::FLAG0_BIT] = flag_ff[0];
         end
         cmp_ctrl_pkg::OFS_IRQ_MASK: rd_val = mask_ff;
         cmp_ctrl_pkg::OFS_OUT_CTL:  rd_val = out_ctl_ff;
         default:                    rd_val = 8'h00;
      endcase
   end

   // Read data captured in the setup cycle, stable through access
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_ff <= 32'h0000_0000;
      end
      else if (rd_setup)
      begin
         prdata_ff <= {24'h00_0000, rd_val};
      end
   end

   // Assertion helpers for protected writes and multi-step events
   sequence s_mode_write(logic [7:0] v);
      psel && penable && pwrite && pstrb[0]
         && paddr == cmp_ctrl_pkg::OFS_MODE && pwdata[7:0] == v;
   endsequence

   sequence s_running;
      run ##1 run;
   endsequence

   sequence s_gated;
      !gate && !blk_rst;
   endsequence

   sequence s_c1_plain(logic a);
      run && en[1] && !win[1] && a;
   endsequence

   sequence s_c1_crossing;
      s_c1_plain(c1_above_high) ##0 !res[1];
   endsequence

   sequence s_c1_event;
      rise[1] ##1 flag_ff[1];
   endsequence

   AST_ABOVE_HIGH: assert property (
      s_c1_plain(c1_above_high) |=> res[1])
      else $error("second result not set above high reference");

   AST_WINDOW: assert property (
      (run && en[1] && win[1]) |=>
      res[1] == $past(c1_above_high || c1_below_low))
      else $error("window result wrong");

   AST_PIN: assert property (
      s_c1_plain(1'b1) ##1 !out_ctl_ff[0] |=>
      pin_ff == $past(c1_above_high, 2))
      else $error("pin does not follow result");

   AST_PIN_INV: assert property (
      out_ctl_ff[0] |=> pin_ff == !$past(res[1]))
      else $error("pin inversion wrong");

   AST_GATE: assert property (
      s_gated |=> $stable(res))
      else $error("results moved with clock gated");

   AST_GATE_WR: assert property (
      s_gated ##0 s_mode_write(8'h11) |=> $stable(mode_ff))
      else $error("mode written with clock gated");

   AST_GATE_PIN: assert property (
      s_gated ##1 s_gated |=> $stable(pin_ff))
      else $error("pin moved with clock gated");

   AST_EN1: assert property (
      s_running ##0 !en[1] |=> !res[1])
      else $error("second comparator active while disabled");

   AST_EN0: assert property (
      (run && en[0] && !win[0] && c0_above_high) |=> res[0])
      else $error("first comparator not enabled");

   AST_EN0_OFF: assert property (
      s_running ##0 !en[0] |=> !res[0])
      else $error("first comparator active while disabled");

   AST_FLAG: assert property (
      rise[1] |=> flag_ff[1])
      else $error("flag missed an event");

   AST_FLAG0: assert property (
      rise[0] |=> flag_ff[0])
      else $error("first flag missed an event");

   AST_EVENT: assert property (
      s_c1_crossing |=> s_c1_event)
      else $error("crossing did not raise a request");

   AST_CLEAR: assert property (
      (wr && paddr == cmp_ctrl_pkg::OFS_IRQ_FLAG && !pwdata[4] && !rise[0])
      |=> !flag_ff[0])
      else $error("flag not cleared by zero write");

   AST_BLK_RST: assert property (
      blk_rst |=> (res == 2'b00 && mode_ff == 8'h00))
      else $error("block reset did not clear channel");

   AST_BLK_PIN: assert property (
      blk_rst |-> ##2 !pin_ff)
      else $error("block reset did not clear pin");

   AST_MON: assert property (
      (rd_setup && paddr == cmp_ctrl_pkg::OFS_MODE) |=>
      prdata[7] == $past(res[1]) && prdata[3] == $past(res[0]))
      else $error("monitor bit wrong");

   AST_WINDOW0: assert property (
      (run && en[0] && win[0]) |=>
      res[0] == $past(c0_above_high || c0_below_low))
      else $error("first window result wrong");

   AST_MASK: assert property (
      (flag_ff != 2'b00 && (flag_ff & ~{mask_ff[5], mask_ff[4]}) == 2'b00)
      |-> !irq)
      else $error("masked request raised interrupt");

   AST_IRQ: assert property (
      (flag_ff[1] && !mask_ff[5]) |-> irq)
      else $error("unmasked second request gave no interrupt");

   AST_IRQ0: assert property (
      (flag_ff[0] && !mask_ff[4]) |-> irq)
      else $error("unmasked first request gave no interrupt");
endmodule

// ---- test/analog_front.sv ----
// Partner model: battery divider and regulator references feeding both
// comparator decisions.
// Assumes the bench changes the levels right after a rising pclk edge.
`timescale 1ns/1ps
module analog_front
(
   input  wire logic [7:0] monitored_input,
   input  wire logic [7:0] high_side_reference,
   input  wire logic [7:0] low_side_reference,
   output logic            above_high,
   output logic            below_low
);
   // Ideal comparators on the divided battery level
   assign above_high = monitored_input > high_side_reference;
   assign below_low  = monitored_input < low_side_reference;
endmodule

// ---- test/tb_top.sv ----
// Self-checking bench for the window comparator control block.
// Assumes APB answers with pready and the partner drives both channels.
`timescale 1ns/1ps
module tb_top;
   typedef struct packed
   {
      logic [7:0] mode;
      logic       inv;
      logic [7:0] vin;
      logic [7:0] hi;
      logic [7:0] lo;
      logic [7:0] exp_rd;
      logic       exp_pin;
   } row_t;

   logic        pclk;
   logic        presetn;
   logic [11:0] paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [3:0]  pstrb;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        ah;
   logic        bl;
   logic        pin;
   logic        irq;
   logic [7:0]  vin;
   logic [7:0]  hi;
   logic [7:0]  lo;
   logic        last_err;
   int          err_count;
   int          check_count;

   localparam row_t ROWS [8] = '{
      '{8'h11, 1'b0, 8'hc8, 8'h96, 8'h32, 8'h99, 1'b1},
      '{8'h11, 1'b1, 8'hc8, 8'h96, 8'h32, 8'h99, 1'b0},
      '{8'h11, 1'b0, 8'h1e, 8'h96, 8'h32, 8'h11, 1'b0},
      '{8'h33, 1'b0, 8'h1e, 8'h96, 8'h32, 8'hbb, 1'b1},
      '{8'h33, 1'b1, 8'h64, 8'h96, 8'h32, 8'h33, 1'b1},
      '{8'h10, 1'b0, 8'hc8, 8'h96, 8'h32, 8'h90, 1'b1},
      '{8'h01, 1'b0, 8'hc8, 8'h96, 8'h32, 8'h09, 1'b0},
      '{8'h21, 1'b0, 8'h1e, 8'h96, 8'h32, 8'h21, 1'b0}};

   cmp_ctrl_top DUT
   (
      .pclk               (pclk),
      .presetn            (presetn),
      .paddr              (paddr),
      .psel               (psel),
      .penable            (penable),
      .pwrite             (pwrite),
      .pwdata             (pwdata),
      .pstrb              (pstrb),
      .prdata             (prdata),
      .pready             (pready),
      .pslverr            (pslverr),
      .c0_above_high      (ah),
      .c0_below_low       (bl),
      .c1_above_high      (ah),
      .c1_below_low       (bl),
      .compare_result_pin (pin),
      .irq                (irq)
   );

   analog_front partner
   (
      .monitored_input     (vin),
      .high_side_reference (hi),
      .low_side_reference  (lo),
      .above_high          (ah),
      .below_low           (bl)
   );

   initial
   begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end

   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, err_count);
      if (err_count == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      check_count++;
      if (got !== exp)
      begin
         err_count++;
         $display("MISMATCH t=%0t bit got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      paddr   <= a;
      pwrite  <= w;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Wait for the answer; only the watchdog ends a hang
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      r        = prdata;
      last_err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      apb(1'b1, a, {24'h0, d}, r);
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [7:0] e);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      chk(r, {24'h0, e});
   endtask

   task automatic analog(input logic [7:0] v);
      @(posedge pclk);
      vin <= v;
      repeat (4) @(negedge pclk);
   endtask

   initial
   begin
      #160000;
      err_count++;
      stop_test();
   end

   initial
   begin
      presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 12'h000; pwdata = 32'h0; pstrb = 4'hf; last_err = 1'b0;
      vin = 8'h64; hi = 8'h96; lo = 8'h32;
      err_count = 0; check_count = 0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(12'h000, 8'h00);
      rd_chk(12'h010, 8'h30);
      rd_chk(12'h008, 8'h00);
      rd_chk(12'h020, 8'h00);
      chk_bit(last_err, 1'b1);
      // Gate closed: mode write has no effect
      wr(12'h008, 8'h11);
      rd_chk(12'h008, 8'h00);
      wr(12'h000, 8'h20);
      wr(12'h010, 8'h00);
      wr(12'h00c, 8'h00);
      @(negedge pclk);
      chk_bit(irq, 1'b0);
      foreach (ROWS[i])
      begin
         wr(12'h014, {7'h0, ROWS[i].inv});
         wr(12'h008, ROWS[i].mode);
         @(posedge pclk);
         hi <= ROWS[i].hi;
         lo <= ROWS[i].lo;
         analog(ROWS[i].vin);
         rd_chk(12'h008, ROWS[i].exp_rd);
         chk_bit(pin, ROWS[i].exp_pin);
      end
      rd_chk(12'h00c, 8'h30);
      @(negedge pclk);
      chk_bit(irq, 1'b1);
      wr(12'h010, 8'h30);
      @(negedge pclk);
      chk_bit(irq, 1'b0);
      rd_chk(12'h00c, 8'h30);
      wr(12'h00c, 8'h20);
      rd_chk(12'h00c, 8'h20);
      wr(12'h00c, 8'h00);
      rd_chk(12'h00c, 8'h00);
      // Gate closed freezes both results
      wr(12'h014, 8'h00);
      wr(12'h008, 8'h11);
      analog(8'hc8);
      wr(12'h000, 8'h00);
      analog(8'h64);
      rd_chk(12'h008, 8'h99);
      chk_bit(pin, 1'b1);
      wr(12'h000, 8'h20);
      repeat (4) @(negedge pclk);
      rd_chk(12'h008, 8'h11);
      // Block reset clears mode and results, keeps flags
      analog(8'hc8);
      wr(12'h004, 8'h20);
      rd_chk(12'h008, 8'h00);
      @(negedge pclk);
      chk_bit(pin, 1'b0);
      wr(12'h008, 8'h11);
      rd_chk(12'h008, 8'h00);
      rd_chk(12'h00c, 8'h30);
      wr(12'h004, 8'h00);
      wr(12'h008, 8'h11);
      repeat (4) @(negedge pclk);
      rd_chk(12'h008, 8'h99);
      // Second reset in mid-run
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      rd_chk(12'h010, 8'h30);
      rd_chk(12'h000, 8'h00);
      rd_chk(12'h008, 8'h00);
      stop_test();
   end
endmodule
